// *** src/sh_consts.vh ***
// constants for the secure messaging helper and read counter
// assumes byte addresses on a 32-bit axi4-lite register bus
`ifndef SH_CONSTS_VH
`define SH_CONSTS_VH

// ****************************************
// register byte offsets
// ****************************************
`define SH_A_OPT     8'h00
`define SH_A_STATE   8'h04
`define SH_A_HCMD    8'h08
`define SH_A_INCR    8'h0C
`define SH_A_CCTR    8'h10
`define SH_A_HSTAT   8'h14
`define SH_A_BPTR    8'h18
`define SH_A_BDATA   8'h1C
`define SH_A_RSEL    8'h20
`define SH_A_RVAL    8'h24
`define SH_A_RASC0   8'h28
`define SH_A_RASC1   8'h2C

// ****************************************
// fields and codes
// ****************************************
`define SH_OPT_HELPER_BIT 7
`define SH_ST_NONE   2'h0
`define SH_ST_ECC    2'h1
`define SH_MODE_INT  2'h1
`define SH_MODE_FULL 2'h3
`define SH_VAR_PROT  1'h0
`define SH_VAR_UNPR  1'h1
`define SH_MAX_LEN   9'h0FF
`define SH_CCTR_TOP  17'h0FFFF
`define SH_E_NONE    3'h0
`define SH_E_DIS     3'h1
`define SH_E_STATE   3'h2
`define SH_E_LEN     3'h3
`define SH_E_CTR     3'h4
`define SH_E_PARAM   3'h5
`define SH_E_MAC     3'h6
`define SH_K_OTHER   2'h0
`define SH_K_NATIVE  2'h1
`define SH_K_ISO     2'h2
`define SH_K_SETTING 2'h3
`define SH_RC_ZERO    24'h000000
`define SH_RC_NOLIMIT 24'h0FFFFF
`define SH_RESP_OK     2'h0
`define SH_RESP_SLVERR 2'h2

`endif

// *** src/sh_buf.v ***
// byte buffer holding helper payloads and results
// assumes one port owner per cycle, chosen by the caller
`timescale 1ns/1ns
module sh_buf #(
  parameter AW = 8,
  parameter DW = 8
) (
  input  wire          aclk,
  input  wire          we,
  input  wire [AW-1:0] addr,
  input  wire [DW-1:0] wdata,
  output reg  [DW-1:0] rdata
);

  // ****************************************
  // storage
  // ****************************************
  reg [DW-1:0] mem [0:(1<<AW)-1];  // payload bytes

  // read first (old data on a write), read data always registered
  always @(posedge aclk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule

// *** src/sh_rdctr.v ***
// per-file dynamic read counters with re-arm and limit logic
// assumes one command event per cycle from the command decoder
`timescale 1ns/1ns
`include "sh_consts.vh"
module sh_rdctr #(
  parameter NFILES = 4,
  parameter FW     = 2
) (
  input  wire          aclk,
  input  wire          aresetn,
  input  wire          cmd_valid,
  input  wire [1:0]    cmd_kind,
  input  wire [FW-1:0] cmd_file,
  input  wire          cmd_cont,
  input  wire          cmd_sdm_en,
  input  wire          cmd_limit_en,
  input  wire [23:0]   cmd_limit,
  input  wire          authed,
  input  wire [FW-1:0] sel,
  output reg  [23:0]   sel_ctr,
  output reg           sel_en,
  output reg           rd_grant,
  output reg           rd_deny
);

  // ****************************************
  // state
  // ****************************************
  reg [23:0]   ctr_reg [0:NFILES-1];  // read counters
  reg          en_reg  [0:NFILES-1];  // dynamic messaging on
  reg [23:0]   lim_reg [0:NFILES-1];  // limit per file
  reg [1:0]    last_kind_reg;         // kind of last command
  reg [FW-1:0] last_file_reg;         // file of last read
  integer      i;

  wire first_rd = (last_kind_reg != cmd_kind) || (last_file_reg != cmd_file);
  wire counts   = !authed && en_reg[cmd_file] && first_rd;
  wire at_lim   = ctr_reg[cmd_file] == lim_reg[cmd_file];

  // command event handling
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (i = 0; i < NFILES; i = i + 1)
      begin
        ctr_reg[i] <= `SH_RC_ZERO;
        en_reg[i]  <= 1'b0;
        lim_reg[i] <= `SH_RC_NOLIMIT;
      end
      last_kind_reg <= `SH_K_OTHER;
      last_file_reg <= {FW{1'b0}};
      sel_ctr       <= `SH_RC_ZERO;
      sel_en        <= 1'b0;
      rd_grant      <= 1'b0;
      rd_deny       <= 1'b0;
    end
    else
    begin
      rd_grant <= 1'b0;
      rd_deny  <= 1'b0;
      sel_ctr  <= ctr_reg[sel];
      sel_en   <= en_reg[sel];
      // later frames of a chain are not new commands
      if (cmd_valid && !cmd_cont)
      begin
        case (cmd_kind)
          `SH_K_NATIVE, `SH_K_ISO:
          begin
            // a change of read kind counts as a first read
            last_kind_reg <= cmd_kind;
            last_file_reg <= cmd_file;
            if (counts && at_lim)
            begin
              rd_deny       <= 1'b1;
              last_kind_reg <= `SH_K_OTHER;
            end
            else
            begin
              rd_grant <= 1'b1;
              // repeated reads keep the current value
              if (counts)
              begin
                ctr_reg[cmd_file] <= ctr_reg[cmd_file] + 24'h000001;
              end
            end
          end
          `SH_K_SETTING:
          begin
            en_reg[cmd_file]  <= cmd_sdm_en;
            lim_reg[cmd_file] <= cmd_limit_en ? cmd_limit : `SH_RC_NOLIMIT;
            if (cmd_sdm_en)
            begin
              ctr_reg[cmd_file] <= `SH_RC_ZERO;
            end
            last_kind_reg <= `SH_K_OTHER;
          end
          default:
          begin
            last_kind_reg <= `SH_K_OTHER;
          end
        endcase
      end
    end
  end

endmodule

// *** src/sh_core.v ***
// helper command sequencer and read counter register front end
// assumes an external mac/cipher engine and a command decoder
//
// How it works
// - plain protect adds increment to command counter
// - reject if counter would reach 0xFFFF
// - reject payloads longer than one short apdu
// - encryption starts at host-given offset
// - integrity protect returns only the mac
// - encrypted protect returns ciphertext plus mac
// - encrypted unprotect returns plaintext, no code
// - 24-bit read counter per file
// - enabling dynamic messaging clears the counter
// - binary lsb first, ascii msb first
// - first unauthenticated read increments by one
// - repeated reads keep the counter value
// - other commands or kind switch re-arm
// - no increment while authenticated
// - counter at limit denies first read
// - chained read counts as one command
// - mode code x0 plain, 01 mac, 11 full
// - helper only in ecc authenticated state
// - helper enabled by option bit 7
`timescale 1ns/1ns
`include "sh_consts.vh"
module sh_core #(
  parameter ADDR_W  = 8,
  parameter MAC_LEN = 9'h008,
  parameter NFILES  = 4,
  parameter FW      = 2
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  output reg               eng_start,
  output reg               eng_unprotect,
  output reg               eng_mac_only,
  output reg  [7:0]        eng_first,
  output reg  [8:0]        eng_len,
  input  wire              eng_done,
  input  wire              eng_mac_ok,
  input  wire [8:0]        eng_out_len,
  input  wire              eng_we,
  input  wire [7:0]        eng_addr,
  input  wire [7:0]        eng_wdata,
  output wire [7:0]        eng_rdata,
  input  wire              cmd_valid,
  input  wire [1:0]        cmd_kind,
  input  wire [FW-1:0]     cmd_file,
  input  wire              cmd_cont,
  input  wire              cmd_sdm_en,
  input  wire              cmd_limit_en,
  input  wire [23:0]       cmd_limit,
  output wire              rd_grant,
  output wire              rd_deny
);

  // ****************************************
  // helpers
  // ****************************************
  // byte-lane merge of a register write
  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer      k;
    begin
      wmerge = old;
      for (k = 0; k < 4; k = k + 1)
      begin
        if (strb[k])
        begin
          wmerge[k*8 +: 8] = nw[k*8 +: 8];
        end
      end
    end
  endfunction

  // one hex digit to upper-case ascii
  function [7:0] hexc;
    input [3:0] n;
    begin
      hexc = (n < 4'hA) ? {4'h3, n} : (8'h37 + {4'h0, n});
    end
  endfunction

  // x0 is plain, so only bit 0 tells protection
  function is_plain;
    input [1:0] m;
    begin
      is_plain = !m[0];
    end
  endfunction

  // ****************************************
  // states and registers
  // ****************************************
  localparam S_IDLE = 1'b0;  // ready for a helper command
  localparam S_ENG  = 1'b1;  // engine owns the buffer

  reg        st_reg;         // helper sequencer state
  reg [7:0]  opt_reg;        // protocol option byte
  reg [1:0]  auth_reg;       // session state
  reg [15:0] incr_reg;       // counter increment amount
  reg [15:0] cctr_reg;       // command counter
  reg        done_reg;       // helper finished
  reg [2:0]  err_reg;        // helper error code
  reg [8:0]  olen_reg;       // result length in buffer
  reg [7:0]  ostart_reg;     // result start in buffer
  reg [1:0]  hmode_reg;      // mode of running command
  reg        hvar_reg;       // variant of running command
  reg [7:0]  bptr_reg;       // buffer pointer
  reg [FW-1:0] rsel_reg;     // counter file select
  reg        rwait_reg;      // read waits on buffer
  reg [7:0]  raddr_reg;      // latched read address

  // ****************************************
  // axi handshakes
  // ****************************************
  wire wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  wire rbusy   = rwait_reg || s_axi_rvalid;
  // writes win the buffer when both arrive together
  assign s_axi_awready = wr_fire;
  assign s_axi_wready  = wr_fire;
  assign s_axi_arready = !rbusy && !(s_axi_awvalid && s_axi_wvalid);
  wire rd_fire = s_axi_arvalid && s_axi_arready;

  wire [7:0]  wa = s_axi_awaddr[7:0];
  wire [7:0]  ra = s_axi_araddr[7:0];
  wire [31:0] wd = wmerge(32'h00000000, s_axi_wdata, s_axi_wstrb);
  // lane merges cut back to register width on purpose
  wire [31:0] opt_m  = wmerge({24'h000000, opt_reg}, s_axi_wdata, s_axi_wstrb);  // option byte merge
  wire [31:0] incr_m = wmerge({16'h0000, incr_reg}, s_axi_wdata, s_axi_wstrb);   // increment merge
  wire [31:0] cctr_m = wmerge({16'h0000, cctr_reg}, s_axi_wdata, s_axi_wstrb);   // counter merge
  wire eng_own   = (st_reg == S_ENG);

  // ****************************************
  // buffer port
  // ****************************************
  wire       buf_we = eng_own ? eng_we : (wr_fire && wa == `SH_A_BDATA);
  wire [7:0] buf_a  = eng_own ? eng_addr : bptr_reg;
  wire [7:0] buf_d  = eng_own ? eng_wdata : wd[7:0];

  sh_buf #(
    .AW (8),
    .DW (8)
  ) u_buf (
    .aclk  (aclk),
    .we    (buf_we),
    .addr  (buf_a),
    .wdata (buf_d),
    .rdata (eng_rdata)
  );

  // ****************************************
  // read counters
  // ****************************************
  wire [23:0] sel_ctr;  // selected counter value
  wire        sel_en;   // selected file enabled

  sh_rdctr #(
    .NFILES (NFILES),
    .FW     (FW)
  ) u_rdctr (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .cmd_valid    (cmd_valid),
    .cmd_kind     (cmd_kind),
    .cmd_file     (cmd_file),
    .cmd_cont     (cmd_cont),
    .cmd_sdm_en   (cmd_sdm_en),
    .cmd_limit_en (cmd_limit_en),
    .cmd_limit    (cmd_limit),
    .authed       (auth_reg != `SH_ST_NONE),
    .sel          (rsel_reg),
    .sel_ctr      (sel_ctr),
    .sel_en       (sel_en),
    .rd_grant     (rd_grant),
    .rd_deny      (rd_deny)
  );

  // ****************************************
  // helper command checks
  // ****************************************
  wire [1:0]  h_mode = wd[1:0];     // requested mode
  wire        h_var  = wd[4];       // protect or unprotect
  wire [8:0]  h_len  = wd[16:8];    // input byte count
  wire [7:0]  h_off  = wd[31:24];   // first payload byte
  wire [16:0] h_sum  = {1'b0, cctr_reg} + {1'b0, incr_reg};
  reg  [2:0]  h_err;                // launch verdict

  // reject causes in priority order
  always @*
  begin
    h_err = `SH_E_NONE;
    if (!opt_reg[`SH_OPT_HELPER_BIT])
    begin
      h_err = `SH_E_DIS;
    end
    else if (auth_reg != `SH_ST_ECC)
    begin
      h_err = `SH_E_STATE;
    end
    else if (h_len > `SH_MAX_LEN)
    begin
      h_err = `SH_E_LEN;
    end
    else if (h_var == `SH_VAR_UNPR && is_plain(h_mode))
    begin
      h_err = `SH_E_PARAM;
    end
    else if (h_var == `SH_VAR_PROT && is_plain(h_mode) && h_sum >= `SH_CCTR_TOP)
    begin
      h_err = `SH_E_CTR;
    end
    else if (h_var == `SH_VAR_PROT && h_mode == `SH_MODE_FULL && {1'b0, h_off} > h_len)
    begin
      h_err = `SH_E_PARAM;
    end
    else if (h_var == `SH_VAR_UNPR && h_len < MAC_LEN + 9'h001)
    begin
      h_err = `SH_E_PARAM;
    end
  end

  // ****************************************
  // registers and helper sequencer
  // ****************************************
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_reg        <= S_IDLE;
      opt_reg       <= 8'h00;
      auth_reg      <= `SH_ST_NONE;
      incr_reg      <= 16'h0000;
      cctr_reg      <= 16'h0000;
      done_reg      <= 1'b0;
      err_reg       <= `SH_E_NONE;
      olen_reg      <= 9'h000;
      ostart_reg    <= 8'h00;
      hmode_reg     <= 2'h0;
      hvar_reg      <= 1'b0;
      bptr_reg      <= 8'h00;
      rsel_reg      <= {FW{1'b0}};
      eng_start     <= 1'b0;
      eng_unprotect <= 1'b0;
      eng_mac_only  <= 1'b0;
      eng_first     <= 8'h00;
      eng_len       <= 9'h000;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SH_RESP_OK;
    end
    else
    begin
      eng_start <= 1'b0;
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
      // buffer pointer steps on each data read unless the engine owns the buffer
      if (rd_fire && ra == `SH_A_BDATA && !eng_own)
      begin
        bptr_reg <= bptr_reg + 8'h01;
      end
      // engine completion closes the command
      if (st_reg == S_ENG && eng_done)
      begin
        st_reg   <= S_IDLE;
        done_reg <= 1'b1;
        if (hvar_reg == `SH_VAR_UNPR && !eng_mac_ok)
        begin
          err_reg  <= `SH_E_MAC;
          olen_reg <= 9'h000;
        end
        else if (hmode_reg == `SH_MODE_INT)
        begin
          // mac only out, or nothing back for unprotect
          olen_reg <= (hvar_reg == `SH_VAR_PROT) ? MAC_LEN : 9'h000;
        end
        else
        begin
          olen_reg <= eng_out_len;
        end
      end
      // register writes
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `SH_RESP_OK;
        case (wa)
          `SH_A_OPT:   opt_reg  <= opt_m[7:0];
          `SH_A_STATE: auth_reg <= wd[1:0];
          `SH_A_INCR:  incr_reg <= incr_m[15:0];
          `SH_A_CCTR:  cctr_reg <= cctr_m[15:0];
          `SH_A_BPTR:  bptr_reg <= wd[7:0];
          `SH_A_RSEL:  rsel_reg <= wd[FW-1:0];
          `SH_A_BDATA:
          begin
            if (eng_own)
            begin
              s_axi_bresp <= `SH_RESP_SLVERR;
            end
            else
            begin
              bptr_reg <= bptr_reg + 8'h01;
            end
          end
          `SH_A_HCMD:
          begin
            if (eng_own)
            begin
              s_axi_bresp <= `SH_RESP_SLVERR;
            end
            else
            begin
              hmode_reg <= h_mode;
              hvar_reg  <= h_var;
              err_reg   <= h_err;
              olen_reg  <= 9'h000;
              if (h_err != `SH_E_NONE)
              begin
                done_reg <= 1'b1;
              end
              else if (is_plain(h_mode))
              begin
                // counter only, no data exchanged
                cctr_reg <= h_sum[15:0];
                done_reg <= 1'b1;
              end
              else
              begin
                done_reg      <= 1'b0;
                st_reg        <= S_ENG;
                eng_start     <= 1'b1;
                eng_unprotect <= h_var;
                eng_mac_only  <= (h_mode == `SH_MODE_INT);
                if (h_var == `SH_VAR_PROT && h_mode == `SH_MODE_FULL)
                begin
                  // cipher from payload start, header never echoed
                  eng_first  <= h_off;
                  eng_len    <= h_len - {1'b0, h_off};
                  ostart_reg <= h_off;
                end
                else if (h_var == `SH_VAR_PROT)
                begin
                  eng_first  <= 8'h00;
                  eng_len    <= h_len;
                  ostart_reg <= 8'h00;
                end
                else
                begin
                  // skip return code byte, never echoed
                  eng_first  <= 8'h01;
                  eng_len    <= h_len - 9'h001;
                  ostart_reg <= 8'h01;
                end
              end
            end
          end
          default:
          begin
            s_axi_bresp <= `SH_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  // two-cycle answer so buffer data is registered
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rwait_reg    <= 1'b0;
      raddr_reg    <= 8'h00;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `SH_RESP_OK;
    end
    else
    begin
      rwait_reg <= rd_fire;
      if (rd_fire)
      begin
        raddr_reg <= ra;
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
      if (rwait_reg)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `SH_RESP_OK;
        case (raddr_reg)
          `SH_A_OPT:   s_axi_rdata <= {24'h000000, opt_reg};
          `SH_A_STATE: s_axi_rdata <= {30'h00000000, auth_reg};
          `SH_A_INCR:  s_axi_rdata <= {16'h0000, incr_reg};
          `SH_A_CCTR:  s_axi_rdata <= {16'h0000, cctr_reg};
          `SH_A_HSTAT: s_axi_rdata <= {7'h00, olen_reg, ostart_reg, 1'b0, err_reg, 2'h0, done_reg, st_reg};
          `SH_A_BPTR:  s_axi_rdata <= {24'h000000, bptr_reg};
          `SH_A_RSEL:  s_axi_rdata <= {{(32-FW){1'b0}}, rsel_reg};
          // binary value, lowest byte in lane 0
          `SH_A_RVAL:  s_axi_rdata <= {7'h00, sel_en, sel_ctr};
          // ascii, most significant digit in lane 0
          `SH_A_RASC0: s_axi_rdata <= {hexc(sel_ctr[11:8]), hexc(sel_ctr[15:12]),
                                       hexc(sel_ctr[19:16]), hexc(sel_ctr[23:20])};
          `SH_A_RASC1: s_axi_rdata <= {16'h0000, hexc(sel_ctr[3:0]), hexc(sel_ctr[7:4])};
          `SH_A_BDATA:
          begin
            s_axi_rdata <= {24'h000000, eng_rdata};
            if (eng_own)
            begin
              s_axi_rresp <= `SH_RESP_SLVERR;
            end
          end
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `SH_RESP_SLVERR;
          end
        endcase
      end
    end
  end

endmodule

// *** dv/sh_core_chk.sv ***
// checker for sh_core bus and counter ports
// assumes a bind by name onto sh_core
`timescale 1ns/1ns
module sh_core_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic eng_start,
  input wire logic cmd_valid,
  input wire logic rd_grant,
  input wire logic rd_deny
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_aw_take: assert property (s_axi_awready == (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid))
    else $error("awready wrong");
  chk_b_next: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("no bvalid");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  chk_r_lat: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_rvalid ##1 s_axi_rvalid)
    else $error("rvalid late");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid dropped");
  chk_start_one: assert property (eng_start |=> !eng_start)
    else $error("start too long");
  chk_pulse_excl: assert property (!(rd_grant && rd_deny))
    else $error("grant and deny");
  chk_grant_src: assert property (rd_grant || rd_deny |-> $past(cmd_valid))
    else $error("pulse without command");
  cover property (rd_deny);
  cover property (rd_grant);
  cover property (eng_start);
endmodule
bind sh_core sh_core_chk u_sh_core_chk (.*);

// *** dv/sh_eng_model.sv ***
// mac and cipher engine stand-in facing sh_core
// assumes start pulses and a bench-chosen result length
`timescale 1ns/1ns
module sh_eng_model (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       eng_start,
  input  wire       slow,
  input  wire       mac_bad,
  input  wire [8:0] olen,
  output reg        eng_done,
  output wire       eng_mac_ok,
  output wire [8:0] eng_out_len
);
  reg [4:0] cnt_reg; // cycles left
  // results only valid beside done
  assign eng_mac_ok  = eng_done && !mac_bad;
  assign eng_out_len = eng_done ? olen : ~olen;
  // countdown from start to done
  always @(posedge aclk)
  begin
    eng_done <= 1'b0;
    if (!aresetn)
      cnt_reg <= 5'h00;
    else if (eng_start)
      cnt_reg <= slow ? 5'h14 : 5'h01;
    else if (cnt_reg != 5'h00)
    begin
      cnt_reg  <= cnt_reg - 5'h01;
      eng_done <= (cnt_reg == 5'h01);
    end
  end
endmodule

// *** dv/tb_top.sv ***
// bench for sh_core over axi4-lite
// assumes sh_eng_model as engine
`timescale 1ns/1ns
`include "sh_consts.vh"
module tb_top;
  reg aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  reg s_axi_arvalid = 0, s_axi_rready = 0, cmd_valid = 0, cmd_cont = 0, slow = 0;
  reg eng_we = 0, cmd_sdm_en = 1, cmd_limit_en = 1, mac_bad = 0;
  reg [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, eng_addr = 0, eng_wdata = 0;
  reg [31:0] s_axi_wdata = 0, q;
  reg [3:0] s_axi_wstrb = 4'hF;
  reg [1:0] cmd_kind = 0, cmd_file = 0, rr, rb;
  reg [23:0] cmd_limit = 24'h000002;
  reg [8:0] olen = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire eng_start, eng_unprotect, eng_mac_only, eng_done, eng_mac_ok, rd_grant, rd_deny;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] eng_first, eng_rdata;
  wire [8:0] eng_len, eng_out_len;
  integer err_count = 0, checks_done = 0, n, k, i;
  sh_core u_sh_core (.*);
  sh_eng_model u_sh_eng_model (.*);
  initial forever #20 aclk = ~aclk;
  task wrap_up;
    begin
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task tmo(input integer c);
    if (c >= 99)
    begin
      err_count = err_count + 1;
      wrap_up;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      checks_done = checks_done + 1;
      if (g !== e)
      begin
        err_count = err_count + 1;
        $display("Error at %0t: got %h want %h", $time, g, e);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      @(posedge aclk);
      for (n = 0; n < 99 && !s_axi_awready; n = n + 1) @(posedge aclk);
      tmo(n);
      s_axi_awvalid <= 0;
      s_axi_wvalid <= 0;
      s_axi_bready <= 1;
      @(posedge aclk);
      for (n = 0; n < 99 && !s_axi_bvalid; n = n + 1) @(posedge aclk);
      rb = s_axi_bresp;
      s_axi_bready <= 0;
      tmo(n);
    end
  endtask
  task rd(input [7:0] a);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      @(posedge aclk);
      for (n = 0; n < 99 && !s_axi_arready; n = n + 1) @(posedge aclk);
      tmo(n);
      s_axi_arvalid <= 0;
      s_axi_rready <= 1;
      @(posedge aclk);
      for (n = 0; n < 99 && !s_axi_rvalid; n = n + 1) @(posedge aclk);
      q = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 0;
      tmo(n);
    end
  endtask
  task rc(input [7:0] a, input [31:0] e);
    begin
      rd(a);
      chk(q, e);
    end
  endtask
  // helper command, then poll status for done
  task hc(input [31:0] c, input [31:0] m, input [31:0] e);
    begin
      wr(`SH_A_HCMD, c);
      q = 0;
      for (k = 0; k < 99 && !q[1]; k = k + 1) rd(`SH_A_HSTAT);
      tmo(k);
      chk(q & m, e);
    end
  endtask
  function [31:0] hw(input [7:0] o, input [8:0] l, input v, input [1:0] m);
    hw = {o, 7'h00, l, 3'h0, v, 2'h0, m};
  endfunction
  function [31:0] hs(input [8:0] l, input [7:0] s, input [2:0] e);
    hs = {7'h00, l, s, 1'b0, e, 4'h2};
  endfunction
  // one command event, grant and deny seen a cycle later
  task ev(input [1:0] t, input c, input dn);
    begin
      cmd_kind <= t;
      cmd_cont <= c;
      cmd_valid <= 1;
      @(posedge aclk);
      cmd_valid <= 0;
      @(posedge aclk);
      chk({rd_grant, rd_deny}, {(t == 1 || t == 2) && !c && !dn, dn});
    end
  endtask
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    rc(`SH_A_OPT, 0);
    rd(8'h40);
    chk(rr, `SH_RESP_SLVERR);
    wr(8'h40, 0);
    chk(rb, `SH_RESP_SLVERR);
    wr(`SH_A_STATE, `SH_ST_ECC);
    hc(hw(0, 1, 0, 1), 32'h72, hs(0, 0, `SH_E_DIS));
    wr(`SH_A_OPT, 32'h80);
    for (i = 0; i < 3; i = i + 2)
    begin
      wr(`SH_A_STATE, i);
      hc(hw(0, 1, 0, 1), 32'h72, hs(0, 0, `SH_E_STATE));
    end
    wr(`SH_A_STATE, `SH_ST_ECC);
    wr(`SH_A_CCTR, 32'hFFE0);
    wr(`SH_A_INCR, 32'h0E);
    for (i = 0; i < 3; i = i + 2)
      hc(hw(0, 0, 0, i), 32'h72, hs(0, 0, 0));
    rc(`SH_A_CCTR, 32'hFFFC);
    wr(`SH_A_INCR, 32'h03);
    hc(hw(0, 0, 0, 0), 32'h72, hs(0, 0, `SH_E_CTR));
    rc(`SH_A_CCTR, 32'hFFFC);
    hc(hw(0, 9'h100, 0, 1), 32'h72, hs(0, 0, `SH_E_LEN));
    hc(hw(0, 9'h0FF, 0, 1), 32'h01FFFF72, hs(8, 0, 0));
    chk({eng_unprotect, eng_mac_only, eng_first, eng_len}, {2'b01, 8'h00, 9'h0FF});
    olen <= 16;
    hc(hw(2, 10, 0, 3), 32'h01FFFF72, hs(16, 2, 0));
    chk({eng_unprotect, eng_mac_only, eng_first, eng_len}, {2'b00, 8'h02, 9'h008});
    hc(hw(11, 10, 0, 3), 32'h72, hs(0, 0, `SH_E_PARAM));
    slow <= 1;
    wr(`SH_A_HCMD, hw(0, 9, 1, 1));
    wr(`SH_A_BDATA, 0);
    chk(rb, `SH_RESP_SLVERR);
    hc(hw(0, 9, 1, 1), 32'h01FF0072, hs(0, 0, 0));
    hc(hw(0, 9, 1, 0), 32'h72, hs(0, 0, `SH_E_PARAM));
    hc(hw(0, 8, 1, 1), 32'h72, hs(0, 0, `SH_E_PARAM));
    mac_bad <= 1;
    hc(hw(0, 25, 1, 3), 32'h01FFFF72, hs(0, 1, `SH_E_MAC));
    mac_bad <= 0;
    hc(hw(0, 25, 1, 3), 32'h01FFFF72, hs(16, 1, 0));
    chk({eng_unprotect, eng_mac_only, eng_first, eng_len}, {2'b10, 8'h01, 9'h018});
    wr(`SH_A_STATE, `SH_ST_NONE);
    ev(3, 0, 0);
    rc(`SH_A_RVAL, 32'h1000000);
    ev(1, 0, 0);
    rc(`SH_A_RVAL, 32'h1000001);
    ev(1, 0, 0);
    ev(1, 1, 0);
    rc(`SH_A_RVAL, 32'h1000001);
    ev(2, 0, 0);
    rc(`SH_A_RVAL, 32'h1000002);
    ev(0, 0, 0);
    ev(2, 0, 1);
    rc(`SH_A_RVAL, 32'h1000002);
    rc(`SH_A_RASC0, 32'h30303030);
    rc(`SH_A_RASC1, 32'h3230);
    cmd_limit_en <= 0;
    ev(3, 0, 0);
    wr(`SH_A_STATE, `SH_ST_ECC);
    ev(1, 0, 0);
    rc(`SH_A_RVAL, 32'h1000000);
    cmd_sdm_en <= 0;
    ev(3, 0, 0);
    rd(`SH_A_RVAL);
    chk(q[24], 0);
    wrap_up;
  end
endmodule
